// file: design/tlr_pkg.sv
package tlr_pkg;
	// register offsets (command codes)
	localparam logic [7:0] TLR_OFF_OT_LIMIT = 8'h4F;
	localparam logic [7:0] TLR_OFF_IIN_LIMIT = 8'h5D;
	localparam logic [7:0] TLR_OFF_PIN_LIMIT = 8'h6B;
	localparam logic [7:0] TLR_OFF_IREF = 8'hE0;
	localparam logic [7:0] TLR_OFF_STATUS_BYTE = 8'h78;
	localparam logic [7:0] TLR_OFF_STATUS_WORD = 8'h79;
	localparam logic [7:0] TLR_OFF_STATUS_OUT = 8'h7A;
	localparam logic [7:0] TLR_OFF_STATUS_INPUT = 8'h7C;
	localparam logic [7:0] TLR_OFF_STATUS_TEMP = 8'h7D;
	localparam logic [7:0] TLR_OFF_VENDOR2 = 8'h81;
	localparam logic [7:0] TLR_OFF_LOG_PTR = 8'hE6;
	localparam logic [7:0] TLR_OFF_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] TLR_OFF_WRITE_LOCK = 8'hFA;
	// host-side registers
	localparam logic [7:0] TLR_HOFF_CMD = 8'h00;
	localparam logic [7:0] TLR_HOFF_WDATA = 8'h01;
	localparam logic [7:0] TLR_HOFF_RDATA = 8'h02;
	localparam logic [7:0] TLR_HOFF_STAT = 8'h03;
	// reset values, limit maximum and unlock key
	localparam logic [15:0] TLR_RST_OT_LIMIT = 16'h0085;
	localparam logic [15:0] TLR_RST_IIN_LIMIT = 16'h00FF;
	localparam logic [15:0] TLR_RST_PIN_LIMIT = 16'h00FF;
	localparam logic [5:0] TLR_RST_IREF = 6'h32;
	localparam logic [7:0] TLR_LIMIT_MAX = 8'hFF;
	localparam logic [7:0] TLR_UNLOCK_KEY = 8'h00;
	// status bit positions
	localparam int TLR_SB_SWITCH_OFF = 6;
	localparam int TLR_SB_TEMP = 2;
	localparam int TLR_SB_OTHER = 0;
	localparam int TLR_SW_OUT = 15;
	localparam int TLR_SW_INPUT = 13;
	localparam int TLR_SW_PGB = 11;
	localparam int TLR_SW_OTHER = 8;
	localparam int TLR_SO_UV_WARN = 5;
	localparam int TLR_SI_PWR_WARN = 0;
	localparam int TLR_SI_CUR_WARN = 1;
	localparam int TLR_ST_OT_FAULT = 7;
	localparam int TLR_V2_PGB = 4;
	localparam int TLR_V2_EOF_WARN = 0;
	// mask bit positions
	localparam int TLR_AM_TEMP = 0;
	localparam int TLR_AM_PGB = 1;
	localparam int TLR_AM_OUT = 2;
	localparam int TLR_AM_IN = 3;
	localparam int TLR_FM_THERMAL = 0;
	// gpio function codes
	localparam logic [2:0] TLR_GPIO_DEDICATED = 3'h0;
	// event log
	localparam logic [2:0] TLR_LOG_LAST = 3'h6;
	localparam int TLR_LOG_DEPTH = 7;
	localparam logic [3:0] TLR_EV_PWR = 4'h1;
	localparam logic [3:0] TLR_EV_CUR = 4'h2;
	typedef enum logic [1:0] {TLR_OP_NONE, TLR_OP_WRITE, TLR_OP_READ} tlr_op_t;
endpackage

// file: design/tlr_if.sv
`timescale 1ns/10ps
interface tlr_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic alert_n;
	modport dev(input wr, input rd, input addr, input wdata, output rdata, output alert_n);
	modport host(output wr, output rd, output addr, output wdata, input rdata, input alert_n);
endinterface

// file: design/tlr_host.sv
`timescale 1ns/10ps
module tlr_host
	import tlr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	tlr_if.host link,
	input wire logic [7:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata,
	output logic alert_seen
);
	import tlr_pkg::*;

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------
	// writing CMD starts one transaction: bit 8 = read, [7:0] = code
	logic [7:0] code_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	tlr_op_t op_q;
	logic rd_pend_q;
	logic [15:0] sw_rdata_q;
	logic [15:0] sw_rdata_d;

	wire cmd_wr = sw_wr && sw_addr == TLR_HOFF_CMD;
	wire wd_wr = sw_wr && sw_addr == TLR_HOFF_WDATA;
	wire [15:0] stat_word = {14'h0000, alert_seen, rd_pend_q};

	always_comb begin
		sw_rdata_d = 16'h0000;
		unique case (sw_addr)
			TLR_HOFF_CMD: sw_rdata_d = {8'h00, code_q};
			TLR_HOFF_WDATA: sw_rdata_d = wdata_q;
			TLR_HOFF_RDATA: sw_rdata_d = rdata_q;
			TLR_HOFF_STAT: sw_rdata_d = stat_word;
			default: sw_rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			code_q <= 8'h00;
			wdata_q <= 16'h0000;
			op_q <= TLR_OP_NONE;
			rd_pend_q <= 1'b0;
			rdata_q <= 16'h0000;
			sw_rdata_q <= 16'h0000;
		end else if (clk_en) begin
			op_q <= TLR_OP_NONE;
			rd_pend_q <= op_q == TLR_OP_READ;
			if (rd_pend_q) rdata_q <= link.rdata;
			if (wd_wr) wdata_q <= sw_wdata;
			if (cmd_wr) begin
				code_q <= sw_wdata[7:0];
				op_q <= sw_wdata[8] ? TLR_OP_READ : TLR_OP_WRITE;
			end
			if (sw_rd) sw_rdata_q <= sw_rdata_d;
		end
	end

	// ------------------------------------------------------------
	// link drive
	// ------------------------------------------------------------
	// software unlocks with write_lock before limit writes
	// clear_faults is issued as a write to its code
	assign link.wr = op_q == TLR_OP_WRITE;
	assign link.rd = op_q == TLR_OP_READ;
	assign link.addr = code_q;
	assign link.wdata = wdata_q;
	assign sw_rdata = sw_rdata_q;
	assign alert_seen = !link.alert_n;
endmodule

// file: design/tlr_dev.sv
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module tlr_dev
	import tlr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	tlr_if.dev link,
	input wire logic [15:0] temp_code,
	input wire logic [15:0] power_code,
	input wire logic [15:0] current_code,
	input wire logic [3:0] alert_mask,
	input wire logic [0:0] fault_mask,
	input wire logic [2:0] pin1_func,
	input wire logic [2:0] pin2_func,
	input wire logic [2:0] pin4_func,
	input wire logic log_free,
	input wire logic [15:0] timestamp,
	output logic [5:0] dac_code,
	output logic power_good,
	output logic fault_pin,
	output logic log_we,
	output logic [2:0] log_addr,
	output logic [19:0] log_data
);
	import tlr_pkg::*;

	// ------------------------------------------------------------
	// limit registers
	// ------------------------------------------------------------
	// limits are raw direct-format codes; no unit conversion here
	logic [15:0] ot_lim_q;
	logic [15:0] iin_lim_q;
	logic [15:0] pin_lim_q;
	logic [5:0] iref_q;
	logic unlocked_q;
	logic ot_q;
	logic pwr_q;
	logic cur_q;
	logic [2:0] ptr_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	// limit and reference writes land only when unlocked, guarding against stray writes; write_lock and clear_faults always act
	wire wr_ok = link.wr && unlocked_q;
	wire lock_wr = link.wr && link.addr == TLR_OFF_WRITE_LOCK;
	wire clr = link.wr && link.addr == TLR_OFF_CLEAR_FAULTS;

	// ------------------------------------------------------------
	// detection
	// ------------------------------------------------------------
	wire ot_now = temp_code > ot_lim_q;
	wire pwr_now = power_code > pin_lim_q;
	wire cur_now = current_code > iin_lim_q;
	// set wins over clear; clear needs the condition to be gone
	wire ot_d = ot_now || (ot_q && !clr);
	wire pwr_d = pwr_now || (pwr_q && !clr);
	wire cur_d = cur_now || (cur_q && !clr);
	wire pwr_rise = pwr_now && !pwr_q;
	wire cur_rise = cur_now && !cur_q;
	wire ev = pwr_rise || cur_rise;
	wire log_go = ev && log_free;
	wire [2:0] ptr_d = ptr_q < TLR_LOG_LAST ? ptr_q + 3'h1 : 3'h0;

	// ------------------------------------------------------------
	// status views
	// ------------------------------------------------------------
	wire in_any = pwr_q || cur_q;
	// flags are widened before shifting so no bit is lost to a one-bit shift
	wire [7:0] st_byte = ({7'h00, ot_q} << TLR_SB_SWITCH_OFF) | ({7'h00, ot_q} << TLR_SB_TEMP)
		| ({7'h00, ot_q || in_any} << TLR_SB_OTHER);
	wire [15:0] st_word = ({15'h0000, ot_q} << TLR_SW_OUT) | ({15'h0000, ot_q} << TLR_SW_PGB)
		| ({15'h0000, in_any} << TLR_SW_INPUT) | ({15'h0000, ot_q || pwr_q} << TLR_SW_OTHER)
		| {8'h00, st_byte};
	wire [7:0] st_out = {7'h00, ot_q} << TLR_SO_UV_WARN;
	wire [7:0] st_in = ({7'h00, pwr_q} << TLR_SI_PWR_WARN) | ({7'h00, cur_q} << TLR_SI_CUR_WARN);
	wire [7:0] st_temp = {7'h00, ot_q} << TLR_ST_OT_FAULT;
	wire [7:0] st_v2 = ({7'h00, ot_q} << TLR_V2_PGB) | ({7'h00, in_any} << TLR_V2_EOF_WARN);

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	wire ot_alert = ot_q && !alert_mask[TLR_AM_TEMP] && !alert_mask[TLR_AM_PGB]
		&& !alert_mask[TLR_AM_OUT];
	wire in_alert = in_any && !alert_mask[TLR_AM_IN];
	assign link.alert_n = !((ot_alert || in_alert) && pin4_func == TLR_GPIO_DEDICATED);
	assign power_good = !(ot_q && pin1_func == TLR_GPIO_DEDICATED);
	assign fault_pin = ot_q && !fault_mask[TLR_FM_THERMAL]
		&& pin2_func == TLR_GPIO_DEDICATED;
	assign dac_code = iref_q;
	assign log_addr = ptr_q;
	assign link.rdata = rdata_q;

	always_comb begin
		rdata_d = 16'h0000;
		unique case (link.addr)
			TLR_OFF_OT_LIMIT: rdata_d = ot_lim_q;
			TLR_OFF_IIN_LIMIT: rdata_d = iin_lim_q;
			TLR_OFF_PIN_LIMIT: rdata_d = pin_lim_q;
			TLR_OFF_IREF: rdata_d = {10'h000, iref_q};
			TLR_OFF_STATUS_BYTE: rdata_d = {8'h00, st_byte};
			TLR_OFF_STATUS_WORD: rdata_d = st_word;
			TLR_OFF_STATUS_OUT: rdata_d = {8'h00, st_out};
			TLR_OFF_STATUS_INPUT: rdata_d = {8'h00, st_in};
			TLR_OFF_STATUS_TEMP: rdata_d = {8'h00, st_temp};
			TLR_OFF_VENDOR2: rdata_d = {8'h00, st_v2};
			TLR_OFF_LOG_PTR: rdata_d = {13'h0000, ptr_q};
			TLR_OFF_WRITE_LOCK: rdata_d = {15'h0000, !unlocked_q};
			default: rdata_d = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ot_lim_q <= TLR_RST_OT_LIMIT;
			iin_lim_q <= TLR_RST_IIN_LIMIT;
			pin_lim_q <= TLR_RST_PIN_LIMIT;
			iref_q <= TLR_RST_IREF;
			unlocked_q <= 1'b0;
			ot_q <= 1'b0;
			pwr_q <= 1'b0;
			cur_q <= 1'b0;
			ptr_q <= 3'h0;
			rdata_q <= 16'h0000;
			log_we <= 1'b0;
			log_data <= 20'h00000;
		end else if (clk_en) begin
			if (lock_wr) unlocked_q <= link.wdata[7:0] == TLR_UNLOCK_KEY;
			if (wr_ok && link.addr == TLR_OFF_OT_LIMIT) ot_lim_q <= {8'h00, link.wdata[7:0]};
			if (wr_ok && link.addr == TLR_OFF_IIN_LIMIT) iin_lim_q <= {8'h00, link.wdata[7:0]};
			if (wr_ok && link.addr == TLR_OFF_PIN_LIMIT) pin_lim_q <= {8'h00, link.wdata[7:0]};
			if (wr_ok && link.addr == TLR_OFF_IREF) iref_q <= link.wdata[5:0];
			ot_q <= ot_d;
			pwr_q <= pwr_d;
			cur_q <= cur_d;
			if (link.rd) rdata_q <= rdata_d;
			log_we <= log_go;
			if (log_go) begin
				log_data <= {pwr_rise ? TLR_EV_PWR : TLR_EV_CUR, timestamp};
				ptr_q <= ptr_d;
			end
		end
	end
endmodule

// file: verification/tlr_assertions.sv
`timescale 1ns/10ps
module tlr_assertions (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic alert_n,
	input wire logic [5:0] dac_code,
	input wire logic [3:0] alert_mask,
	input wire logic [2:0] pin4_func,
	input wire logic log_we,
	input wire logic log_free,
	input wire logic [2:0] log_addr,
	input wire logic [19:0] log_data
);
	logic open_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ----
	// lock state mirrored from the link, so reference writes can be judged
	// ----
	always_ff @(posedge ref_clk) begin
		if (!rst_n) open_q <= 1'b0;
		else if (wr && addr == 8'hFA) open_q <= (wdata[7:0] == 8'h00);
	end
	dac_reset_a: assert property ($rose(rst_n) |-> dac_code == 6'h32)
		else $error("reference code off default after reset");
	dac_write_a: assert property (wr && addr == 8'hE0 && open_q
		|=> {10'h000, dac_code} == ($past(wdata) & 16'h003F)) else $error("reference write lost");
	dac_locked_a: assert property (wr && addr == 8'hE0 && !open_q |=> $stable(dac_code))
		else $error("reference changed while locked");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	alert_gate_a: assert property ((pin4_func != 3'h0 || alert_mask == 4'hF) |-> alert_n)
		else $error("alert raised while masked or pin not alert");
	log_ptr_a: assert property (log_we |-> log_addr ==
		(($past(log_addr) == 3'h6) ? 3'h0 : $past(log_addr) + 3'h1)) else $error("pointer step wrong");
	log_free_a: assert property (log_we |-> $past(log_free))
		else $error("log written with no free entry");
	log_id_a: assert property (log_we |-> log_data[19:16] inside {4'h1, 4'h2})
		else $error("log event id unknown");
	cover property (log_we && log_addr == 3'h6);
	cover property (!alert_n);
	cover property (wr && addr == 8'hE0 && open_q);
endmodule

// file: verification/threshold_limit_registers_test.sv
`timescale 1ns/10ps
module threshold_limit_registers_test;
	import tlr_pkg::*;
	logic ref_clk, rst_n, clk_en, sw_wr, sw_rd, alert_seen, log_free, power_good, fault_pin, log_we;
	logic [7:0] sw_addr;
	logic [15:0] sw_wdata, sw_rdata, temp_code, power_code, current_code, v;
	logic [3:0] alert_mask;
	logic [0:0] fault_mask;
	logic [2:0] pin1_func, pin2_func, pin4_func, log_addr;
	logic [5:0] dac_code;
	logic [19:0] log_data;
	int n_errors, samples_checked, n_log;
	tlr_if link();
	tlr_host tlr_host_i(.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .alert_seen(alert_seen));
	tlr_dev tlr_dev_i(.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link),
		.temp_code(temp_code), .power_code(power_code), .current_code(current_code),
		.alert_mask(alert_mask), .fault_mask(fault_mask), .pin1_func(pin1_func),
		.pin2_func(pin2_func), .pin4_func(pin4_func), .log_free(log_free),
		.timestamp(16'h5A3C), .dac_code(dac_code), .power_good(power_good),
		.fault_pin(fault_pin), .log_we(log_we), .log_addr(log_addr), .log_data(log_data));
	tlr_assertions tlr_assertions_i(.ref_clk(ref_clk), .rst_n(rst_n), .wr(link.wr), .rd(link.rd),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .alert_n(link.alert_n),
		.dac_code(dac_code), .alert_mask(alert_mask), .pin4_func(pin4_func), .log_we(log_we),
		.log_free(log_free), .log_addr(log_addr), .log_data(log_data));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) if (log_we === 1'b1) n_log++;
	// ----
	// helpers
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic sw_op(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		sw_wr <= w;
		sw_rd <= !w;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
		@(posedge ref_clk);
		v = sw_rdata;
	endtask
	// one device command through the host; a read leaves its result in v
	task automatic dev(input logic [7:0] c, input logic [15:0] d, input logic r);
		sw_op(1'b1, TLR_HOFF_WDATA, d);
		sw_op(1'b1, TLR_HOFF_CMD, {7'h00, r, c});
		repeat (4) @(posedge ref_clk);
		if (r) sw_op(1'b0, TLR_HOFF_RDATA, 16'h0000);
	endtask
	task automatic wait_log();
		int k;
		for (k = 0; k < 20 && log_we !== 1'b1; k++) @(negedge ref_clk);
		if (k == 20) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		dev(a, 16'h0000, 1'b1);
		check(v & m, e);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		rd_chk(TLR_OFF_OT_LIMIT, 16'hFFFF, 16'h0085);
		rd_chk(TLR_OFF_IIN_LIMIT, 16'hFFFF, 16'h00FF);
		rd_chk(TLR_OFF_PIN_LIMIT, 16'hFFFF, 16'h00FF);
		rd_chk(TLR_OFF_IREF, 16'hFFFF, 16'h0032);
		check({10'h000, dac_code}, 16'h0032);
	endtask
	task automatic t_lock();
		dev(TLR_OFF_OT_LIMIT, 16'h0090, 1'b0);
		rd_chk(TLR_OFF_OT_LIMIT, 16'hFFFF, 16'h0085);
		dev(TLR_OFF_WRITE_LOCK, 16'h0000, 1'b0);
		dev(TLR_OFF_OT_LIMIT, 16'h0090, 1'b0);
		dev(TLR_OFF_IREF, 16'h003F, 1'b0);
		rd_chk(TLR_OFF_OT_LIMIT, 16'hFFFF, 16'h0090);
		check({10'h000, dac_code}, 16'h003F);
	endtask
	task automatic t_overtemp();
		@(posedge ref_clk);
		temp_code <= 16'h0091;
		rd_chk(TLR_OFF_STATUS_BYTE, 16'h00FF, 16'h0045);
		rd_chk(TLR_OFF_STATUS_WORD, 16'hFF00, 16'h8900);
		rd_chk(TLR_OFF_STATUS_OUT, 16'h0020, 16'h0020);
		rd_chk(TLR_OFF_STATUS_TEMP, 16'h0080, 16'h0080);
		rd_chk(TLR_OFF_VENDOR2, 16'h0010, 16'h0010);
		check({13'h0000, alert_seen, power_good, fault_pin}, 16'h0005);
		alert_mask <= 4'h1;
		fault_mask <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check({14'h0000, alert_seen, fault_pin}, 16'h0000);
		alert_mask <= 4'h0;
		fault_mask <= 1'b0;
		pin4_func <= 3'h1;
		pin1_func <= 3'h1;
		pin2_func <= 3'h1;
		repeat (2) @(posedge ref_clk);
		check({13'h0000, alert_seen, power_good, fault_pin}, 16'h0002);
		{pin1_func, pin2_func, pin4_func} <= '0;
		dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd_chk(TLR_OFF_STATUS_BYTE, 16'h00FF, 16'h0045);
		temp_code <= 16'h0000;
		dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd_chk(TLR_OFF_STATUS_BYTE, 16'h00FF, 16'h0000);
	endtask
	task automatic t_input();
		@(posedge ref_clk);
		power_code <= 16'h0100;
		wait_log();
		check({9'h000, log_data[19:16], log_addr}, 16'h0009);
		check(log_data[15:0], 16'h5A3C);
		rd_chk(TLR_OFF_STATUS_INPUT, 16'h0003, 16'h0001);
		rd_chk(TLR_OFF_STATUS_WORD, 16'hFF00, 16'h2100);
		rd_chk(TLR_OFF_STATUS_BYTE, 16'h00FF, 16'h0001);
		check({15'h0000, alert_seen}, 16'h0001);
		sw_op(1'b0, TLR_HOFF_STAT, 16'h0000);
		check(v & 16'h0002, 16'h0002);
		dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd_chk(TLR_OFF_STATUS_INPUT, 16'h0001, 16'h0001);
		power_code <= 16'h0000;
		dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd_chk(TLR_OFF_STATUS_INPUT, 16'h0003, 16'h0000);
		// seven events walk the pointer through 6 and back to 0
		for (int i = 1; i < 8; i++) begin
			@(posedge ref_clk);
			current_code <= 16'h0100;
			wait_log();
			check({9'h000, log_data[19:16], log_addr}, {9'h000, 4'h2, 3'((i + 1) % 7)});
			@(posedge ref_clk);
			current_code <= 16'h0000;
			dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		end
		log_free <= 1'b0;
		current_code <= 16'h0100;
		rd_chk(TLR_OFF_STATUS_INPUT, 16'h0003, 16'h0002);
		rd_chk(TLR_OFF_STATUS_WORD, 16'hFF00, 16'h2000);
		check(16'(n_log), 16'h0008);
		rd_chk(TLR_OFF_LOG_PTR, 16'h0007, 16'h0001);
		current_code <= 16'h0000;
		dev(TLR_OFF_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd_chk(TLR_OFF_STATUS_INPUT, 16'h0003, 16'h0000);
	endtask
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		{sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
		{temp_code, power_code, current_code} = '0;
		{alert_mask, fault_mask, pin1_func, pin2_func, pin4_func} = '0;
		log_free = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_lock();
		t_overtemp();
		t_input();
		wrap_up();
	end
endmodule
